// *** hw/rsk_counter_stack.sv ***
// Instruction-address counter with latches, return stack and Wishbone registers
//
// Functional notes
// - Counter is 21 bits held as low, high and upper bytes.
// - Low byte read/write; high byte reached only through the high latch.
// - Upper byte reached only through the upper latch.
// - Writing low byte copies both latches into the counter together.
// - Reading low byte copies counter high and upper bytes into latches.
// - Counter bit 0 is always zero.
// - Sequential execution advances the counter by two.
// - Call, goto and branch load target directly, latches not transferred.
// - Stack is 31 entries of 21 bits, 5-bit pointer, separate space.
// - Call and interrupt acknowledge push the counter.
// - Return, return-with-literal and return-from-interrupt pop into counter.
// - Calls and returns leave both latches unchanged.
// - Push increments pointer first, then writes the following address for a call, the counter itself for an interrupt.
// - Pop loads counter from selected entry, then decrements pointer.
// - Reset clears pointer; pointer zero has no entry behind it.
// - Status flags report full, overflow and underflow.
// - Software reads and writes pointer and top entry bytes.
// - Top registers always show the entry selected by the pointer.
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module rsk_counter_stack
    import rsk_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [WB_ADR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [WB_DAT_W-1:0] wbDatIn,
    output logic [WB_DAT_W-1:0] wbDatOut,
    output logic wbAck,
    input wire logic [OP_W-1:0] seqOp,
    input wire logic [ADDR_W-1:0] seqTarget,
    output logic seqReady,
    output logic [ADDR_W-1:0] instrAddrCounter,
    output logic [PTR_W-1:0] returnStackPointer,
    output logic stackFull,
    output logic stackOverflow,
    output logic stackUnderflow
);

    function automatic logic [ADDR_W-1:0] alignAddr(input logic [ADDR_W-1:0] addr);
        alignAddr = addr & ALIGN_MASK;
    endfunction

    function automatic logic regHit(input logic [WB_ADR_W-1:0] adr, input logic [WB_ADR_W-1:0] off);
        regHit = ({adr[WB_ADR_W-1:2], 2'b00} == off);
    endfunction

    logic [7:0] highByteLatch;
    logic [UPPER_W-1:0] upperByteLatch;
    logic [ADDR_W-1:0] next_instrAddrCounter;
    logic [7:0] next_highByteLatch;
    logic [UPPER_W-1:0] next_upperByteLatch;
    logic [PTR_W-1:0] next_returnStackPointer;
    logic next_stackFull;
    logic next_stackOverflow;
    logic next_stackUnderflow;
    logic [WB_DAT_W-1:0] next_wbDatOut;

    // Bus decode
    wire busTake = wbCyc && wbStb && !wbAck;
    wire busWr = busTake && wbWe && wbSel[0];
    wire busRd = busTake && !wbWe;
    wire hitLow = regHit(wbAdr, OFF_COUNTER_LOW);
    wire hitHigh = regHit(wbAdr, OFF_HIGH_LATCH);
    wire hitUpper = regHit(wbAdr, OFF_UPPER_LATCH);
    wire hitPtr = regHit(wbAdr, OFF_STACK_PTR);
    wire hitTopLow = regHit(wbAdr, OFF_TOP_LOW);
    wire hitTopHigh = regHit(wbAdr, OFF_TOP_HIGH);
    wire hitTopUpper = regHit(wbAdr, OFF_TOP_UPPER);
    wire hitStatus = regHit(wbAdr, OFF_STACK_STATUS);
    wire wrLow = busWr && hitLow;
    wire rdLow = busRd && hitLow;
    wire wrTop = busWr && (hitTopLow || hitTopHigh || hitTopUpper);
    wire [7:0] wrByte = wbDatIn[7:0];

    // A bus access owns the cycle; the sequencer waits one cycle
    assign seqReady = !busTake;
    wire seqTake = (seqOp != OP_NONE) && !busTake;
    wire opPush = seqTake && ((seqOp == OP_CALL) || (seqOp == OP_INT_ACK));
    wire opPop = seqTake && (seqOp == OP_RETURN);

    // Stack pointer arithmetic
    wire ptrAtFull = (returnStackPointer == PTR_FULL);
    wire ptrAtEmpty = (returnStackPointer == PTR_EMPTY);
    wire [PTR_W-1:0] ptrUp = returnStackPointer + PTR_STEP;
    wire [PTR_W-1:0] ptrDown = returnStackPointer - PTR_STEP;
    wire pushDone = opPush && !ptrAtFull;
    wire popDone = opPop && !ptrAtEmpty;

    // Selected entry; the top registers are views of it
    wire [ADDR_W-1:0] topEntry;
    wire [ADDR_W-1:0] sequentialAddr = instrAddrCounter + COUNTER_STEP;
    // Call pushes the address after itself; an interrupt pushes the one it preempted
    wire [ADDR_W-1:0] pushValue = (seqOp == OP_CALL) ? sequentialAddr : instrAddrCounter;
    wire [ADDR_W-1:0] topMerged = hitTopLow ? {topEntry[ADDR_W-1:8], wrByte} :
        hitTopHigh ? {topEntry[ADDR_W-1:16], wrByte, topEntry[7:0]} :
        {wrByte[UPPER_W-1:0], topEntry[15:0]};

    // Writes at pointer zero are dropped, there is no storage behind it
    wire ramWrEn = pushDone || (wrTop && !ptrAtEmpty);
    wire [PTR_W-1:0] ramWrPtr = pushDone ? ptrUp : returnStackPointer;
    wire [ADDR_W-1:0] ramWrData = pushDone ? pushValue : topMerged;

    rsk_stack_ram u_stack (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(ramWrEn),
        .wrPtr(ramWrPtr),
        .wrData(ramWrData),
        .rdPtr(returnStackPointer),
        .rdData(topEntry)
    );

    // Counter next value
    always_comb begin
        next_instrAddrCounter = instrAddrCounter;
        if (wrLow) begin
            next_instrAddrCounter = alignAddr({upperByteLatch, highByteLatch, wrByte});
        end else if (seqTake) begin
            case (seqOp)
                OP_ADVANCE: next_instrAddrCounter = alignAddr(sequentialAddr);
                OP_JUMP: next_instrAddrCounter = alignAddr(seqTarget);
                OP_CALL: next_instrAddrCounter = alignAddr(seqTarget);
                OP_INT_ACK: next_instrAddrCounter = alignAddr(seqTarget);
                // Underflow returns zero since the empty slot reads as zero
                OP_RETURN: next_instrAddrCounter = alignAddr(topEntry);
                default: next_instrAddrCounter = instrAddrCounter;
            endcase
        end
    end

    // Latches move only by their own writes or a low-byte read
    always_comb begin
        next_highByteLatch = highByteLatch;
        next_upperByteLatch = upperByteLatch;
        if (rdLow) begin
            next_highByteLatch = instrAddrCounter[15:8];
            next_upperByteLatch = instrAddrCounter[ADDR_W-1:16];
        end else if (busWr && hitHigh) begin
            next_highByteLatch = wrByte;
        end else if (busWr && hitUpper) begin
            next_upperByteLatch = wrByte[UPPER_W-1:0];
        end
    end

    // Pointer next value
    always_comb begin
        next_returnStackPointer = returnStackPointer;
        if (busWr && hitPtr) begin
            next_returnStackPointer = wrByte[PTR_W-1:0];
        end else if (pushDone) begin
            next_returnStackPointer = ptrUp;
        end else if (popDone) begin
            next_returnStackPointer = ptrDown;
        end
    end

    // Sticky flags, write one to clear; a new event beats the clear
    wire clrStatus = busWr && hitStatus;
    wire setFull = pushDone && (ptrUp == PTR_FULL);
    wire setOverflow = opPush && ptrAtFull;
    wire setUnderflow = opPop && ptrAtEmpty;
    assign next_stackFull = setFull || (stackFull && !(clrStatus && wrByte[STAT_FULL_BIT]));
    assign next_stackOverflow = setOverflow ||
        (stackOverflow && !(clrStatus && wrByte[STAT_OVERFLOW_BIT]));
    assign next_stackUnderflow = setUnderflow ||
        (stackUnderflow && !(clrStatus && wrByte[STAT_UNDERFLOW_BIT]));

    // Read data; the high and upper counter bytes have no read path
    wire [2:0] statusBits = {stackUnderflow, stackOverflow, stackFull};
    always_comb begin
        next_wbDatOut = '0;
        if (busRd) begin
            if (hitLow) begin
                next_wbDatOut[7:0] = instrAddrCounter[7:0];
            end else if (hitHigh) begin
                next_wbDatOut[7:0] = highByteLatch;
            end else if (hitUpper) begin
                next_wbDatOut[UPPER_W-1:0] = upperByteLatch;
            end else if (hitPtr) begin
                next_wbDatOut[PTR_W-1:0] = returnStackPointer;
            end else if (hitTopLow) begin
                next_wbDatOut[7:0] = topEntry[7:0];
            end else if (hitTopHigh) begin
                next_wbDatOut[7:0] = topEntry[15:8];
            end else if (hitTopUpper) begin
                next_wbDatOut[UPPER_W-1:0] = topEntry[ADDR_W-1:16];
            end else if (hitStatus) begin
                next_wbDatOut[2:0] = statusBits;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instrAddrCounter <= COUNTER_RESET;
            highByteLatch <= BYTE_RESET;
            upperByteLatch <= UPPER_RESET;
        end else begin
            instrAddrCounter <= next_instrAddrCounter;
            highByteLatch <= next_highByteLatch;
            upperByteLatch <= next_upperByteLatch;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            returnStackPointer <= PTR_EMPTY;
            stackFull <= 1'b0;
            stackOverflow <= 1'b0;
            stackUnderflow <= 1'b0;
        end else begin
            returnStackPointer <= next_returnStackPointer;
            stackFull <= next_stackFull;
            stackOverflow <= next_stackOverflow;
            stackUnderflow <= next_stackUnderflow;
        end
    end

    // Unmapped addresses are acked, read zero and ignore writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wbAck <= 1'b0;
            wbDatOut <= '0;
        end else begin
            wbAck <= busTake;
            wbDatOut <= next_wbDatOut;
        end
    end

endmodule // rsk_counter_stack

// *** common/rsk_pkg.sv ***
// Constants shared by the instruction-address counter and its return stack
package rsk_pkg;

    localparam int ADDR_W = 21;
    localparam int UPPER_W = 5;
    localparam int PTR_W = 5;
    localparam int STACK_DEPTH = 31;
    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;

    localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
    localparam logic [PTR_W-1:0] PTR_FULL = 5'h1f;
    localparam logic [PTR_W-1:0] PTR_STEP = 5'h01;
    localparam logic [ADDR_W-1:0] COUNTER_STEP = 21'h000002;
    localparam logic [ADDR_W-1:0] COUNTER_RESET = 21'h000000;
    localparam logic [ADDR_W-1:0] ALIGN_MASK = 21'h1ffffe;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [UPPER_W-1:0] UPPER_RESET = 5'h00;

    // Register byte offsets on the Wishbone slave
    localparam logic [WB_ADR_W-1:0] OFF_COUNTER_LOW = 8'h00;
    localparam logic [WB_ADR_W-1:0] OFF_HIGH_LATCH = 8'h04;
    localparam logic [WB_ADR_W-1:0] OFF_UPPER_LATCH = 8'h08;
    localparam logic [WB_ADR_W-1:0] OFF_STACK_PTR = 8'h0c;
    localparam logic [WB_ADR_W-1:0] OFF_TOP_LOW = 8'h10;
    localparam logic [WB_ADR_W-1:0] OFF_TOP_HIGH = 8'h14;
    localparam logic [WB_ADR_W-1:0] OFF_TOP_UPPER = 8'h18;
    localparam logic [WB_ADR_W-1:0] OFF_STACK_STATUS = 8'h1c;

    // Stack status register bits
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_OVERFLOW_BIT = 1;
    localparam int STAT_UNDERFLOW_BIT = 2;

    // Sequencer commands
    localparam int OP_W = 3;
    localparam logic [OP_W-1:0] OP_NONE = 3'h0;
    localparam logic [OP_W-1:0] OP_ADVANCE = 3'h1;
    localparam logic [OP_W-1:0] OP_JUMP = 3'h2;
    localparam logic [OP_W-1:0] OP_CALL = 3'h3;
    localparam logic [OP_W-1:0] OP_INT_ACK = 3'h4;
    localparam logic [OP_W-1:0] OP_RETURN = 3'h5;

endpackage

// *** hw/rsk_stack_ram.sv ***
// Return stack storage, entries 1 to 31 behind pointer values 1 to 31
`timescale 1ns/1ps
module rsk_stack_ram
    import rsk_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [PTR_W-1:0] wrPtr,
    input wire logic [ADDR_W-1:0] wrData,
    input wire logic [PTR_W-1:0] rdPtr,
    output logic [ADDR_W-1:0] rdData
);

    logic [ADDR_W-1:0] entry [1:STACK_DEPTH];

    genvar i;
    generate
        for (i = 1; i <= STACK_DEPTH; i++) begin : g_entry
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    entry[i] <= COUNTER_RESET;
                end else if (wrEn && (wrPtr == PTR_W'(i))) begin
                    entry[i] <= wrData;
                end
            end
        end
    endgenerate

    // Pointer zero has no storage and reads as zero
    assign rdData = (rdPtr == PTR_EMPTY) ? COUNTER_RESET : entry[rdPtr];

endmodule // rsk_stack_ram

// *** tb/rsk_counter_stack_props.sv ***
// Port checker for the counter and return stack
`timescale 1ns/1ps
module rsk_counter_stack_props
    import rsk_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wbAck,
    input wire logic [OP_W-1:0] seqOp,
    input wire logic [ADDR_W-1:0] seqTarget,
    input wire logic seqReady,
    input wire logic [ADDR_W-1:0] instrAddrCounter,
    input wire logic [PTR_W-1:0] returnStackPointer,
    input wire logic stackFull,
    input wire logic stackOverflow,
    input wire logic stackUnderflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic push = seqReady && (seqOp == OP_CALL || seqOp == OP_INT_ACK);
    wire logic pop = seqReady && seqOp == OP_RETURN;
    wire logic [PTR_W-1:0] sp = returnStackPointer;
    wire logic [ADDR_W-1:0] cnt = instrAddrCounter;
    a_aligned_counter: assert property (cnt[0] == 1'b0)
        else $error("counter odd");
    a_advance_by_two: assert property (seqReady && seqOp == OP_ADVANCE |=> cnt == $past(cnt) + COUNTER_STEP)
        else $error("advance step wrong");
    a_jump_direct: assert property (seqReady && seqOp == OP_JUMP |=> cnt == ($past(seqTarget) & ALIGN_MASK))
        else $error("jump target wrong");
    a_push_raises: assert property (push && sp != PTR_FULL |=> sp == $past(sp) + PTR_STEP)
        else $error("push pointer wrong");
    a_pop_lowers: assert property (pop && sp != PTR_EMPTY |=> sp == $past(sp) - PTR_STEP)
        else $error("pop pointer wrong");
    a_full_at_top: assert property (push && sp == PTR_FULL - PTR_STEP |=> sp == PTR_FULL && stackFull)
        else $error("full not set");
    a_overflow_sets: assert property (push && sp == PTR_FULL |=> sp == PTR_FULL && stackOverflow)
        else $error("overflow not set");
    a_underflow_sets: assert property (pop && sp == PTR_EMPTY |=> sp == PTR_EMPTY && stackUnderflow)
        else $error("underflow not set");
    a_reset_empty: assert property ($rose(rst_n) |-> sp == PTR_EMPTY && cnt == COUNTER_RESET)
        else $error("reset state wrong");
    c_overflow: cover property (push && sp == PTR_FULL);
    c_underflow: cover property (pop && sp == PTR_EMPTY);
    c_bus_ack: cover property (wbAck);
    c_full: cover property (push && sp == PTR_FULL - PTR_STEP);
endmodule // rsk_counter_stack_props

bind rsk_counter_stack rsk_counter_stack_props u_props (.clk(clk), .rst_n(rst_n), .wbAck(wbAck), .seqOp(seqOp),
    .seqTarget(seqTarget), .seqReady(seqReady), .instrAddrCounter(instrAddrCounter),
    .returnStackPointer(returnStackPointer), .stackFull(stackFull), .stackOverflow(stackOverflow),
    .stackUnderflow(stackUnderflow));

// *** tb/rsk_seq_model.sv ***
// Stand-in for the instruction sequencer, one command at a time
`timescale 1ns/1ps
module rsk_seq_model
    import rsk_pkg::*;
(
    input wire logic clk,
    input wire logic seqReady,
    output logic [OP_W-1:0] seqOp,
    output logic [ADDR_W-1:0] seqTarget,
    output logic stuck
);
    initial begin
        seqOp = OP_NONE;
        seqTarget = COUNTER_RESET;
        stuck = 1'b0;
    end
    task automatic issue(input logic [OP_W-1:0] op, input logic [ADDR_W-1:0] tgt);
        int n;
        @(posedge clk);
        seqOp <= op;
        seqTarget <= tgt;
        n = 0;
        // A bus access stalls the core, so the command stays up
        do begin
            @(posedge clk);
            n++;
        end while (seqReady !== 1'b1 && n < 50);
        seqOp <= OP_NONE;
        // Idle target flips so nothing leans on a stale value
        seqTarget <= ~tgt;
        stuck <= (seqReady !== 1'b1);
        @(negedge clk);
    endtask
endmodule // rsk_seq_model

// *** tb/rsk_counter_stack_tb.sv ***
// Self-checking bench for the counter and return stack
`timescale 1ns/1ps
module rsk_counter_stack_tb;
    import rsk_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [WB_ADR_W-1:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h1;
    logic [WB_DAT_W-1:0] wbDatIn = 32'h0, wbDatOut, rd;
    logic wbAck, seqReady, stuck, stackFull, stackOverflow, stackUnderflow;
    logic [OP_W-1:0] seqOp, op;
    logic [ADDR_W-1:0] seqTarget, instrAddrCounter, exp, lat, t;
    logic [PTR_W-1:0] returnStackPointer;
    logic [ADDR_W-1:0] stk[$];
    int nErrors = 0, checksDone = 0, seed = 32'hbde2fe1e;
    always #20 clk = ~clk;
    rsk_counter_stack dut (.clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .seqOp(seqOp), .seqTarget(seqTarget),
        .seqReady(seqReady), .instrAddrCounter(instrAddrCounter), .returnStackPointer(returnStackPointer),
        .stackFull(stackFull), .stackOverflow(stackOverflow), .stackUnderflow(stackUnderflow));
    rsk_seq_model seq (.clk(clk), .seqReady(seqReady), .seqOp(seqOp), .seqTarget(seqTarget), .stuck(stuck));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_word(input string w, input logic [WB_DAT_W-1:0] e, input logic [WB_DAT_W-1:0] g);
        checksDone++;
        if (g !== e) begin
            nErrors++;
            $display("unexpected %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_addr(input string w, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
        chk_word(w, WB_DAT_W'(e), WB_DAT_W'(g));
    endtask
    function automatic logic [ADDR_W-1:0] pushed(input logic [OP_W-1:0] o, input logic [ADDR_W-1:0] c);
        return (o == OP_CALL) ? c + COUNTER_STEP : c;
    endfunction
    task automatic wb(input logic we, input logic [WB_ADR_W-1:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatIn <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) begin
            nErrors++;
            report_and_stop();
        end
    endtask
    task automatic step(input logic [OP_W-1:0] o, input logic [ADDR_W-1:0] tg);
        seq.issue(o, tg);
        if (stuck !== 1'b0) begin
            nErrors++;
            report_and_stop();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_word("pointer", 32'h0, {27'h0, returnStackPointer});
        wb(1'b1, OFF_HIGH_LATCH, 8'h12);
        wb(1'b1, OFF_UPPER_LATCH, 8'h1b);
        wb(1'b1, OFF_COUNTER_LOW, 8'h35);
        chk_addr("latched load", 21'h1b1234, instrAddrCounter);
        wb(1'b0, 8'h20, 8'h00);
        chk_word("unmapped", 32'h0, rd);
        $display("test latch load done");
        t = ADDR_W'($random(seed));
        step(OP_JUMP, t);
        exp = (t & ALIGN_MASK) + COUNTER_STEP;
        step(OP_ADVANCE, ~t);
        chk_addr("advance", exp, instrAddrCounter);
        for (int k = 0; k < 3; k++) begin
            wb(1'b0, OFF_COUNTER_LOW + 8'(4 * k), 8'h00);
            chk_word("counter byte", WB_DAT_W'(exp >> (8 * k)) & 32'hff, rd);
        end
        lat = exp;
        for (int i = 0; i < 32; i++) begin
            op = ($random(seed) & 1) ? OP_CALL : OP_INT_ACK;
            t = ADDR_W'($random(seed));
            if (i < 31) stk.push_back(pushed(op, exp));
            step(op, t);
            exp = t & ALIGN_MASK;
            chk_addr("call target", exp, instrAddrCounter);
        end
        chk_word("flags", 32'h3, {29'h0, stackUnderflow, stackOverflow, stackFull});
        chk_word("pointer", 32'h1f, {27'h0, returnStackPointer});
        wb(1'b0, OFF_STACK_STATUS, 8'h00);
        chk_word("status register", 32'h3, rd);
        for (int k = 0; k < 3; k++) begin
            wb(1'b0, OFF_TOP_LOW + 8'(4 * k), 8'h00);
            chk_word("top byte", WB_DAT_W'(stk[$] >> (8 * k)) & 32'hff, rd);
        end
        wb(1'b1, OFF_STACK_STATUS, 8'h07);
        $display("test push done");
        for (int i = 0; i < 32; i++) begin
            step(OP_RETURN, ADDR_W'($random(seed)));
            exp = (stk.size() > 0) ? stk.pop_back() & ALIGN_MASK : COUNTER_RESET;
            chk_addr("return", exp, instrAddrCounter);
        end
        chk_word("flags", 32'h4, {29'h0, stackUnderflow, stackOverflow, stackFull});
        wb(1'b0, OFF_HIGH_LATCH, 8'h00);
        chk_word("high latch", {24'h0, lat[15:8]}, rd);
        $display("test pop done");
        wb(1'b1, OFF_STACK_PTR, 8'h02);
        for (int k = 0; k < 3; k++) wb(1'b1, OFF_TOP_LOW + 8'(4 * k), 8'(21'h1c9a56 >> (8 * k)));
        wb(1'b0, OFF_STACK_PTR, 8'h00);
        chk_word("pointer", 32'h2, rd);
        step(OP_RETURN, 21'h0);
        chk_addr("soft entry", 21'h1c9a56, instrAddrCounter);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_word("pointer", 32'h0, {27'h0, returnStackPointer});
        chk_addr("counter after reset", COUNTER_RESET, instrAddrCounter);
        $display("test software stack done");
        report_and_stop();
    end
endmodule // rsk_counter_stack_tb
